/* File: oled_cmd_defines.svh */
// Constants for the display command decoder: opcodes, reset values, counts
// Assumes inclusion by bare name from the package and design files
`ifndef OLED_CMD_DEFINES_SVH
`define OLED_CMD_DEFINES_SVH
`define OP_CONTRAST     8'h81
`define OP_MUX          8'ha8
`define OP_CONV         8'had
`define OP_OFFSET       8'hd3
`define RST_CONTRAST    8'h80
`define RST_MUX         6'h3f
`define RST_START       6'h00
`define RST_OFFSET      6'h00
`define RST_COL         8'h00
`define COL_LIMIT       8'h84
`define MODE_SEP        2'h0
`define MODE_ENA        2'h1
`define MODE_SER        2'h2
`endif

/* File: oled_cmd_pkg.sv */
// Types shared by the display command decoder files
// Assumes the defines header sits in the same folder
`include "oled_cmd_defines.svh"
package oled_cmd_pkg;
    typedef enum logic [2:0] {
        ST_OPCODE   = 3'b000,
        ST_CONTRAST = 3'b001,
        ST_MUX      = 3'b010,
        ST_CONV     = 3'b011,
        ST_OFFSET   = 3'b100
    } dec_state_e;
    typedef logic [1:0] host_mode_t;
endpackage

/* File: oled_sync2.sv */
// Two-flop synchroniser for a vector of pin inputs
// Assumes the inputs are asynchronous to i_clk_sys
`timescale 1ns/1ps
`default_nettype none
module oled_sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_nrst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    // Reset value zero; callers choose pin polarity accordingly
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= '0;
            o_q    <= '0;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: oled_host_port.sv */
// Host port front end: turns strobes or serial bits into one write or read pulse
// Assumes synchronised pins; strobes far slower than i_clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "oled_cmd_defines.svh"
module oled_host_port
    import oled_cmd_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire host_mode_t  i_mode,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_e,
    input  wire logic        i_rw,
    input  wire logic        i_cs_n,
    input  wire logic        i_sclk,
    input  wire logic        i_sdin,
    input  wire logic        i_dc,
    input  wire logic [7:0]  i_data,
    output logic             o_wr,
    output logic             o_rd,
    output logic             o_dc,
    output logic [7:0]       o_byte
);
    logic       wr_n_d_r;
    logic       rd_n_d_r;
    logic       e_d_r;
    logic       sclk_d_r;
    logic [7:0] shift_r;
    logic [2:0] bit_cnt_r;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_n_d_r <= 1'b1;
            rd_n_d_r <= 1'b1;
            e_d_r    <= 1'b0;
            sclk_d_r <= 1'b0;
        end else begin
            wr_n_d_r <= i_wr_n;
            rd_n_d_r <= i_rd_n;
            e_d_r    <= i_e;
            sclk_d_r <= i_sclk;
        end
    end
    // Serial: MSB first, shifter cleared on reset, bit counter cleared on reset and while deselected
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_r   <= 8'h00; // R02
            bit_cnt_r <= 3'h0;
        end else if (i_cs_n) begin
            bit_cnt_r <= 3'h0;
        end else if (i_sclk && !sclk_d_r) begin
            shift_r   <= {shift_r[6:0], i_sdin}; // R07
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end
    // Access completes on the trailing edge of the strobe
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wr   <= 1'b0;
            o_rd   <= 1'b0;
            o_dc   <= 1'b0;
            o_byte <= 8'h00;
        end else begin
            o_wr <= 1'b0;
            o_rd <= 1'b0;
            o_dc <= i_dc;
            if (i_mode == `MODE_SER) begin
                if (!i_cs_n && i_sclk && !sclk_d_r && bit_cnt_r == 3'h7) begin
                    o_wr   <= 1'b1;
                    o_byte <= {shift_r[6:0], i_sdin}; // R07
                end
            end else if (i_mode == `MODE_ENA) begin
                if (!i_cs_n && !i_e && e_d_r) begin // R06
                    o_wr   <= !i_rw;
                    o_rd   <= i_rw;
                    o_byte <= i_data;
                end
            end else if (!i_cs_n) begin
                if (i_wr_n && !wr_n_d_r) begin // R05
                    o_wr   <= 1'b1;
                    o_byte <= i_data;
                end else if (i_rd_n && !rd_n_d_r) begin // R05
                    o_rd <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: oled_cmd_decoder.sv */
// Command decoder and settings state of a dot-matrix display controller
// Assumes host pins are asynchronous; RAM sits outside behind o_ram_*
//
// What this block does
// [R01] RC oscillator runs only while oscillator select is high, else external.
// [R02] Reset: display off, outputs high-Z, shifter clear, normal mapping/scan.
// [R03] Reset: start line 00H, column zero, contrast 80H.
// [R04] Commands execute on the internal clock; no busy poll needed.
// [R05] Separate-strobe mode: low read pulse reads, low write pulse writes.
// [R06] Enable-strobe mode: rw high reads, low writes; high enable pulse.
// [R07] Serial bytes arrive most significant bit first.
// [R08] 00H-0FH load column low nibble, 10H-1FH high nibble.
// [R09] Column increments after each data access up to 132; page unchanged.
// [R10] 40H-7FH load six-bit start line, taking effect immediately.
// [R11] After 81H the next byte is contrast, then contrast mode ends.
// [R12] 256 contrast steps, drive rising monotonically with the value.
// [R13] Host should program contrast 80H when not adjusting it.
// [R14] A0H/A1H set segment reverse from bit 0; reset normal.
// [R15] A4H/A5H entire display on, overriding inverse; reset off.
// [R16] A6H/A7H select normal or inverse display; reset normal.
// [R17] After A8H next byte low six bits give mux ratio minus one.
// [R18] After ADH, 8AH/8BH clear or set converter enable; reset set.
// [R19] Converter runs only with converter enable and display on.
// [R20] AEH/AFH display off (sleep) or on; RAM access still allowed.
// [R21] B0H-B7H load three-bit page address.
// [R22] C0H-C8H set common scan reverse from bit 3.
// [R23] After D3H next byte low six bits give display offset.
// [R24] Host must not issue reserved or undefined codes.
// [R25] Data write below column 132 stores byte at current page and column, then advances.
// [R26] Pending-parameter state makes the next command byte a parameter.
`timescale 1ns/1ps
`default_nettype none
`include "oled_cmd_defines.svh"
module oled_cmd_decoder
    import oled_cmd_pkg::*;
#(
    parameter int COL_W = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_nrst,
    input  wire logic             i_ext_display_clock_pin,
    input  wire logic             i_internal_osc_select,
    input  wire logic             i_rc_osc_clk,
    input  wire host_mode_t       i_mode,
    input  wire logic             i_cs_n,
    input  wire logic             i_rd_n,
    input  wire logic             i_wr_n,
    input  wire logic             i_e,
    input  wire logic             i_rw,
    input  wire logic             i_sclk,
    input  wire logic             i_sdin,
    input  wire logic             i_cmd_data_select,
    input  wire logic [7:0]       i_data,
    output logic                  o_osc_enable,
    output logic                  o_display_clk,
    output logic                  o_display_on,
    output logic                  o_outputs_hiz,
    output logic                  o_converter_run,
    output logic                  o_converter_en,
    output logic                  o_ext_supply_needed,
    output logic [COL_W-1:0]      o_column,
    output logic [2:0]            o_page,
    output logic [5:0]            o_start_line,
    output logic [7:0]            o_contrast,
    output logic [7:0]            o_segment_drive_current,
    output logic                  o_seg_reverse,
    output logic                  o_entire_on,
    output logic                  o_inverse,
    output logic [6:0]            o_mux_ratio,
    output logic                  o_com_reverse,
    output logic [5:0]            o_offset,
    output logic                  o_ram_we,
    output logic                  o_ram_re,
    output logic [2:0]            o_ram_page,
    output logic [COL_W-1:0]      o_ram_col,
    output logic [7:0]            o_ram_wdata
);
    logic [1:0]       rst_sync_r;
    logic             rst_n;
    logic [15:0]      pins_s;
    logic             wr_p;
    logic             rd_p;
    logic             dc;
    logic [7:0]       byte_v;
    dec_state_e       state_r;
    logic [COL_W-1:0] col_r;
    logic             disp_on_r;
    logic             conv_en_r;
    logic [5:0]       mux_r;
    logic             cmd_wr;
    logic [2:0]       clk_pins_s;

    // Reset released through two flops so every register leaves reset together
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Strobes synchronised at idle level zero; active-low pins inverted first
    oled_sync2 #(.W(16)) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (rst_n),
        .i_d       ({~i_cs_n, ~i_rd_n, ~i_wr_n, i_e, i_rw, i_sclk,
                     i_sdin, i_cmd_data_select, i_data}),
        .o_q       (pins_s)
    );

    // Strap and display clock pins also cross into i_clk_sys before use
    oled_sync2 #(.W(3)) u_sync_clk (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (rst_n),
        .i_d       ({i_internal_osc_select, i_rc_osc_clk,
                     i_ext_display_clock_pin}),
        .o_q       (clk_pins_s)
    );

    oled_host_port u_port (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n),
        .i_mode    (i_mode),
        .i_rd_n    (~pins_s[14]),
        .i_wr_n    (~pins_s[13]),
        .i_e       (pins_s[12]),
        .i_rw      (pins_s[11]),
        .i_cs_n    (~pins_s[15]),
        .i_sclk    (pins_s[10]),
        .i_sdin    (pins_s[9]),
        .i_dc      (pins_s[8]),
        .i_data    (pins_s[7:0]),
        .o_wr      (wr_p),
        .o_rd      (rd_p),
        .o_dc      (dc),
        .o_byte    (byte_v)
    );

    assign cmd_wr = wr_p && !dc; // R04

    // Parameter bytes are consumed whatever their value; no opcode decoding
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_OPCODE;
        end else if (cmd_wr) begin
            case (state_r)
                ST_OPCODE: begin
                    if (byte_v == `OP_CONTRAST) begin
                        state_r <= ST_CONTRAST; // R11
                    end else if (byte_v == `OP_MUX) begin
                        state_r <= ST_MUX; // R26
                    end else if (byte_v == `OP_CONV) begin
                        state_r <= ST_CONV; // R26
                    end else if (byte_v == `OP_OFFSET) begin
                        state_r <= ST_OFFSET; // R26
                    end
                end
                default: state_r <= ST_OPCODE; // R11
            endcase
        end
    end

    // Column: nibble loads, and advance after each data access, capped
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            col_r <= `RST_COL; // R03
        end else if (cmd_wr && state_r == ST_OPCODE && byte_v[7:5] == 3'b000) begin
            if (byte_v[4]) begin
                col_r[7:4] <= byte_v[3:0]; // R08
            end else begin
                col_r[3:0] <= byte_v[3:0]; // R08
            end
        end else if ((wr_p || rd_p) && dc && col_r < `COL_LIMIT) begin
            col_r <= col_r + 8'h01; // R09
        end
    end

    // Single-byte settings
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_start_line  <= `RST_START; // R03
            o_page        <= 3'h0;
            o_seg_reverse <= 1'b0; // R02
            o_entire_on   <= 1'b0;
            o_inverse     <= 1'b0;
            disp_on_r     <= 1'b0; // R02
            o_com_reverse <= 1'b0; // R02
        end else if (cmd_wr && state_r == ST_OPCODE) begin
            if (byte_v[7:6] == 2'b01) begin
                o_start_line <= byte_v[5:0]; // R10
            end else if (byte_v[7:1] == 7'h50) begin
                o_seg_reverse <= byte_v[0]; // R14
            end else if (byte_v[7:1] == 7'h52) begin
                o_entire_on <= byte_v[0]; // R15
            end else if (byte_v[7:1] == 7'h53) begin
                o_inverse <= byte_v[0]; // R16
            end else if (byte_v[7:1] == 7'h57) begin
                disp_on_r <= byte_v[0]; // R20
            end else if (byte_v[7:3] == 5'h16) begin
                o_page <= byte_v[2:0]; // R21
            end else if (byte_v[7:4] == 4'hc) begin
                o_com_reverse <= byte_v[3]; // R22
            end
        end
    end

    // Two-byte command parameters; converter byte checked against 8AH/8BH
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_contrast <= `RST_CONTRAST; // R03
            mux_r      <= `RST_MUX;
            conv_en_r  <= 1'b1;
            o_offset   <= `RST_OFFSET;
        end else if (cmd_wr) begin
            case (state_r)
                ST_CONTRAST: o_contrast <= byte_v; // R11
                ST_MUX:      mux_r <= byte_v[5:0]; // R17
                ST_CONV: begin
                    if (byte_v[7:1] == 7'h45) begin
                        conv_en_r <= byte_v[0]; // R18
                    end
                end
                ST_OFFSET:   o_offset <= byte_v[5:0]; // R23
                default:     mux_r <= mux_r;
            endcase
        end
    end

    // Derived outputs, all registered; sleep stops oscillator and converter
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_display_on            <= 1'b0;
            o_outputs_hiz           <= 1'b1; // R02
            o_osc_enable            <= 1'b0;
            o_display_clk           <= 1'b0;
            o_converter_run         <= 1'b0;
            o_converter_en          <= 1'b1;
            o_ext_supply_needed     <= 1'b0;
            o_mux_ratio             <= 7'h40;
            o_column                <= `RST_COL;
            o_segment_drive_current <= 8'h00;
        end else begin
            o_display_on  <= disp_on_r;
            o_outputs_hiz <= !disp_on_r; // R20
            o_osc_enable  <= clk_pins_s[2] && disp_on_r; // R01
            // Clock mux glitches possible; select is meant as a static strap
            o_display_clk <= clk_pins_s[2] ? clk_pins_s[1]
                                           : clk_pins_s[0]; // R01
            o_converter_run     <= conv_en_r && disp_on_r; // R19
            o_converter_en      <= conv_en_r;
            o_ext_supply_needed <= !conv_en_r && disp_on_r; // R19
            o_mux_ratio         <= {1'b0, mux_r} + 7'h01; // R17
            o_column            <= col_r;
            o_segment_drive_current <= disp_on_r ? o_contrast : 8'h00; // R12
        end
    end

    // RAM write port; reads are pulsed so the outer RAM can return data
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_ram_we    <= 1'b0;
            o_ram_re    <= 1'b0;
            o_ram_page  <= 3'h0;
            o_ram_col   <= `RST_COL;
            o_ram_wdata <= 8'h00;
        end else begin
            o_ram_we   <= wr_p && dc && col_r < `COL_LIMIT; // R25
            o_ram_re   <= rd_p && dc;
            o_ram_page <= o_page; // R25
            o_ram_col  <= col_r;
            o_ram_wdata <= byte_v; // R25
        end
    end

    contrast_hold_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (cmd_wr && state_r == ST_CONTRAST) |=> ##1 (o_contrast == $past(byte_v, 2)
        && state_r == ST_OPCODE)) else $error("contrast not stored"); // R11
    col_step_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (wr_p && dc && col_r < `COL_LIMIT) |=> col_r == $past(col_r) + 8'h01)
        else $error("column did not advance"); // R09
    col_cap_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        col_r <= `COL_LIMIT) else $error("column beyond limit"); // R09
    conv_run_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        o_converter_run |-> $past(conv_en_r && disp_on_r))
        else $error("converter ran while off"); // R19
    hiz_off_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        o_outputs_hiz == !o_display_on) else $error("hiz mismatch"); // R20
    mux_param_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (cmd_wr && state_r == ST_MUX) ##1 1 ##1 1 |->
        o_mux_ratio == {1'b0, $past(byte_v[5:0], 2)} + 7'h01)
        else $error("mux ratio wrong"); // R17
    param_state_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (cmd_wr && state_r == ST_OPCODE && byte_v == `OP_OFFSET) |=>
        state_r == ST_OFFSET) else $error("offset param not pending"); // R26
    ram_write_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        (wr_p && dc && col_r < `COL_LIMIT) |=> (o_ram_we && o_ram_col ==
        $past(col_r) && o_ram_wdata == $past(byte_v)))
        else $error("ram write wrong"); // R25
    osc_gate_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
        o_osc_enable |-> $past(clk_pins_s[2]))
        else $error("oscillator ran deselected"); // R01
endmodule
`default_nettype wire

/* File: oled_host_model.sv */
// Host processor model that drives the decoder's host pins
// Assumes a free-running i_clk_sys and a static i_mode per reset
`timescale 1ns/1ps
`default_nettype none
`include "oled_cmd_defines.svh"
module oled_host_model
    import oled_cmd_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire host_mode_t i_mode,
    output logic            o_cs_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic            o_e,
    output logic            o_rw,
    output logic            o_sclk,
    output logic            o_sdin,
    output logic            o_cmd_data_select,
    output logic [7:0]      o_data
);
    initial begin
        o_cs_n = 1'b1;
        o_rd_n = 1'b1;
        o_wr_n = 1'b1;
        o_e = 1'b0;
        o_rw = 1'b0;
        o_sclk = 1'b0;
        o_sdin = 1'b0;
        o_cmd_data_select = 1'b0;
        o_data = 8'h00;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    // Levels held 4 clocks, two above what the synchronisers need
    // Callers issue defined codes, except one 55H converter parameter after ADH
    task automatic access(input logic dc, input logic rd, input logic [7:0] b);
        int k;
        @(posedge i_clk_sys);
        o_cs_n <= 1'b0;
        o_cmd_data_select <= dc;
        o_data <= b;
        o_rw <= rd;
        hold(4);
        if (i_mode == `MODE_SER) begin
            for (k = 7; k >= 0; k--) begin
                o_sdin <= b[k];
                hold(4);
                o_sclk <= 1'b1;
                hold(4);
                o_sclk <= 1'b0;
            end
        end else if (i_mode == `MODE_ENA) begin
            o_e <= 1'b1;
            hold(4);
            o_e <= 1'b0;
        end else if (rd) begin
            o_rd_n <= 1'b0;
            hold(4);
            o_rd_n <= 1'b1;
        end else begin
            o_wr_n <= 1'b0;
            hold(4);
            o_wr_n <= 1'b1;
        end
        hold(4);
        o_cs_n <= 1'b1;
        // A released bus must not keep showing the last byte
        o_data <= ~b;
        o_sdin <= ~b[0];
        hold(4);
    endtask
endmodule
`default_nettype wire

/* File: tb_oled_cmd_decoder.sv */
// Self-checking bench for the display command decoder
// Assumes the host model file and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(8'(g), 8'(e))
module tb_oled_cmd_decoder;
    import oled_cmd_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, ext_clk = 1'b0, osc_sel = 1'b1, rc_clk = 1'b0;
    host_mode_t mode = 2'h0;
    logic cs_n, rd_n, wr_n, e, rw, sclk, sdin, dcs;
    logic [7:0] data, column, contrast, drive, ram_col, ram_wd;
    logic osc_en, dclk, disp_on, hiz, conv_run, conv_en, ext_sup, seg_rev;
    logic entire, inverse, com_rev, ram_we, ram_re;
    logic [2:0] page, ram_pg;
    logic [5:0] start, offset;
    logic [6:0] mux;
    logic [7:0] last_col, last_wd;
    logic [2:0] last_pg;
    int num_errors = 0, check_count = 0, we_cnt = 0, re_cnt = 0, k;
    logic [7:0] set_op [5] = '{8'ha1, 8'ha5, 8'ha7, 8'hc8, 8'haf};
    logic [7:0] clr_op [5] = '{8'ha0, 8'ha4, 8'ha6, 8'hc7, 8'hae};

    initial forever #2.5 clk = ~clk;
    always @(posedge clk) rc_clk <= ~rc_clk;
    always @(posedge clk) begin
        if (ram_we === 1'b1) begin
            we_cnt++;
            last_col <= ram_col;
            last_pg <= ram_pg;
            last_wd <= ram_wd;
        end
        if (ram_re === 1'b1) begin
            re_cnt++;
        end
    end

    oled_host_model i_host (.i_clk_sys(clk), .i_mode(mode), .o_cs_n(cs_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_e(e), .o_rw(rw), .o_sclk(sclk),
        .o_sdin(sdin), .o_cmd_data_select(dcs), .o_data(data));

    oled_cmd_decoder i_dut (.i_clk_sys(clk), .i_nrst(nrst),
        .i_ext_display_clock_pin(ext_clk), .i_internal_osc_select(osc_sel),
        .i_rc_osc_clk(rc_clk), .i_mode(mode), .i_cs_n(cs_n), .i_rd_n(rd_n),
        .i_wr_n(wr_n), .i_e(e), .i_rw(rw), .i_sclk(sclk), .i_sdin(sdin),
        .i_cmd_data_select(dcs), .i_data(data), .o_osc_enable(osc_en),
        .o_display_clk(dclk), .o_display_on(disp_on), .o_outputs_hiz(hiz),
        .o_converter_run(conv_run), .o_converter_en(conv_en),
        .o_ext_supply_needed(ext_sup), .o_column(column), .o_page(page),
        .o_start_line(start), .o_contrast(contrast),
        .o_segment_drive_current(drive), .o_seg_reverse(seg_rev),
        .o_entire_on(entire), .o_inverse(inverse), .o_mux_ratio(mux),
        .o_com_reverse(com_rev), .o_offset(offset), .o_ram_we(ram_we),
        .o_ram_re(ram_re), .o_ram_page(ram_pg), .o_ram_col(ram_col),
        .o_ram_wdata(ram_wd));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic do_reset(input host_mode_t m);
        nrst <= 1'b0;
        mode <= m;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic wc(input logic [7:0] b);
        i_host.access(1'b0, 1'b0, b);
    endtask

    function automatic logic flag(input int n);
        case (n)
            0: return seg_rev;
            1: return entire;
            2: return inverse;
            3: return com_rev;
            default: return disp_on;
        endcase
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    initial begin
        do_reset(2'h0);
        `CHK(disp_on, 1'b0);
        `CHK(hiz, 1'b1);
        `CHK({seg_rev, com_rev, entire, inverse}, 4'h0);
        `CHK(contrast, 8'h80);
        `CHK(start, 6'h00);
        `CHK(mux, 7'd64);
        `CHK(conv_en, 1'b1);
        `CHK(offset, 6'h00);
        wc(8'hb5);
        `CHK(page, 3'h5);
        wc(8'h02);
        wc(8'h18);
        `CHK(column, 8'h82);
        i_host.access(1'b1, 1'b1, 8'h00);
        `CHK(re_cnt, 1);
        `CHK(column, 8'h83);
        i_host.access(1'b1, 1'b0, 8'h5a);
        `CHK(we_cnt, 1);
        `CHK(last_pg, 3'h5);
        `CHK(last_col, 8'h83);
        `CHK(last_wd, 8'h5a);
        i_host.access(1'b1, 1'b0, 8'hc3);
        `CHK(we_cnt, 1);
        `CHK(column, 8'h84);
        `CHK(page, 3'h5);
        wc(8'h7f);
        `CHK(start, 6'd63);
        wc(8'h81);
        wc(8'ha5);
        `CHK(contrast, 8'ha5);
        `CHK(entire, 1'b0);
        `CHK(drive, 8'h00);
        wc(8'haf);
        `CHK(drive, 8'ha5);
        `CHK(osc_en, 1'b1);
        wc(8'hae);
        wc(8'h81);
        wc(8'h80);
        `CHK(contrast, 8'h80);
        for (k = 0; k < 5; k++) begin
            wc(set_op[k]);
            `CHK(flag(k), 1'b1);
            wc(clr_op[k]);
            `CHK(flag(k), 1'b0);
        end
        wc(8'ha8);
        wc(8'hcf);
        `CHK(mux, 7'd16);
        wc(8'ha8);
        wc(8'h00);
        `CHK(mux, 7'd1);
        wc(8'hd3);
        wc(8'hff);
        `CHK(offset, 6'd63);
        wc(8'had);
        wc(8'h8a);
        `CHK(conv_en, 1'b0);
        wc(8'haf);
        `CHK({ext_sup, conv_run, hiz}, 3'b100);
        wc(8'hae);
        wc(8'had);
        wc(8'h55);
        `CHK(conv_en, 1'b0);
        wc(8'had);
        wc(8'h8b);
        wc(8'haf);
        `CHK({conv_en, ext_sup, conv_run}, 3'b101);
        osc_sel <= 1'b0;
        ext_clk <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK({osc_en, dclk}, 2'b01);
        ext_clk <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(dclk, 1'b0);
        do_reset(2'h1);
        `CHK(column, 8'h00);
        wc(8'h55);
        `CHK(start, 6'h15);
        i_host.access(1'b1, 1'b1, 8'h00);
        `CHK(re_cnt, 2);
        i_host.access(1'b1, 1'b0, 8'h11);
        `CHK(we_cnt, 2);
        do_reset(2'h2);
        wc(8'h4a);
        `CHK(start, 6'h0a);
        wc(8'hb3);
        `CHK(page, 3'h3);
        complete_run();
    end
endmodule
`default_nettype wire
